// ==== logic/srw_consts.vh ====
// constants shared by the supervisor, watchdog and serial front end
`ifndef SRW_CONSTS_VH
`define SRW_CONSTS_VH

`define SRW_CLK_HZ          40000000
`define SRW_STRETCH_MS      11'h0C8
`define SRW_WD_LONG_MS      11'h578
`define SRW_WD_MID_MS       11'h258
`define SRW_WD_SHORT_MS     11'h0C8
`define SRW_TICK_US         1000
`define SRW_TICK_CYCLES     ((`SRW_CLK_HZ / 1000000) * `SRW_TICK_US)
`define SRW_MS_W            11

`define SRW_SR_LOCK_BIT     7
`define SRW_SR_FLAG_BIT     6
`define SRW_SR_PER_HI_BIT   5
`define SRW_SR_PER_LO_BIT   4
`define SRW_SR_BLK_HI_BIT   3
`define SRW_SR_BLK_LO_BIT   2
`define SRW_SR_WEL_BIT      1
`define SRW_SR_BUSY_BIT     0
`define SRW_SR_RESET        8'h30

`define SRW_PER_LONG        2'h0
`define SRW_PER_MID         2'h1
`define SRW_PER_SHORT       2'h2
`define SRW_PER_OFF         2'h3

`define SRW_OP_WREN         8'h06
`define SRW_OP_SFLB         8'h00
`define SRW_OP_WRDI         8'h04
`define SRW_OP_RDSR         8'h05
`define SRW_OP_WRSR         8'h01

`endif

// ==== logic/srw_sync.v ====
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module srw_sync (
    input  wire CLK,
    input  wire SRST,
    input  wire RST_VAL,
    input  wire D,
    output reg  Q
);
    reg meta;

    // meta feeds only the second stage
    always @(posedge CLK) begin
        if (SRST) begin
            // both stages load the caller's safe level, so no false edge follows reset
            meta <= RST_VAL;
            Q    <= RST_VAL;
        end else begin
            meta <= D;
            Q    <= meta;
        end
    end
endmodule // srw_sync

// ==== logic/srw_mscount.v ====
// millisecond counter that restarts on demand and flags a limit
`timescale 1ns/100ps
`include "srw_consts.vh"
module srw_mscount (
    input  wire                   CLK,
    input  wire                   SRST,
    input  wire                   TICK,
    input  wire                   CLEAR,
    input  wire [`SRW_MS_W-1:0]   LIMIT,
    output wire                   DONE
);
    reg [`SRW_MS_W-1:0] count;

    assign DONE = (count >= LIMIT);

    // saturates at the limit so a held condition stays flagged
    always @(posedge CLK) begin
        if (SRST || CLEAR) begin
            count <= {`SRW_MS_W{1'b0}};
        end else if (TICK && !DONE) begin
            count <= count + {{(`SRW_MS_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // srw_mscount

// ==== logic/srw_supervisor.v ====
// supervisor: power reset stretch, watchdog and status-register serial front end
//
// Operation
// - select high: output released, device in standby unless writing
// - select low: device active and accepts serial traffic
// - no operation until first falling select edge after power-up
// - every falling select edge restarts the watchdog count
// - no falling edge within the timeout drives reset active
// - select held constant high or low past timeout forces reset
// - input sampled on serial clock rise, most significant bit first
// - output changes on serial clock fall, driven both levels
// - reset active while supply is below trip level, polarity by variant
// - reset held 200ms after supply recovers; a dip restarts it
// - power-up reset held 200ms after supply is stable
// - reset stays asserted as supply falls down to 1V
// - serial instructions ignored while reset is active
// - two status bits select the watchdog period
// - period bits locked while protect pin low and lock bit set
// - same lock guards the block-protection bits
// - period codes: 1.4s, 600ms, 200ms, or disabled (default)
// - lock bit 7, period bits 5 and 4
`timescale 1ns/100ps
`include "srw_consts.vh"
module srw_supervisor #(
    parameter ACTIVE_HIGH_RESET = 0,
    parameter TICK_CYCLES       = `SRW_TICK_CYCLES
) (
    input  wire       CLK,
    input  wire       SRST,
    input  wire       SUPPLY_LOW,
    input  wire       SELECT_AND_KICK_INPUT_N,
    input  wire       SCK,
    input  wire       SI,
    input  wire       WRITE_PROTECT_N,
    input  wire       NV_WRITE_BUSY,
    input  wire [7:0] SR_INIT,
    output reg        SO_OUT,
    output wire       SO_OE,
    output wire       RESET_OUT,
    output wire       RESET_OE,
    output wire       STANDBY,
    output wire [7:0] STATUS_REG,
    output reg        WD_EXPIRED
);
    localparam ST_IDLE = 2'h0;
    localparam ST_CMD  = 2'h1;
    localparam ST_RD   = 2'h2;
    localparam ST_WR   = 2'h3;

    wire       sel_n;
    wire       sck_s;
    wire       si_s;
    wire       low_s;
    reg        sel_n_d;
    reg        sck_d;
    reg [1:0]  state;
    reg [2:0]  bit_cnt;
    reg [7:0]  shift;
    reg [7:0]  status;
    reg [7:0]  out_sr;
    reg        armed;
    reg        in_reset;
    reg [31:0] tick_cnt;
    reg        tick;
    reg        loaded;
    reg [`SRW_MS_W-1:0] wd_limit;
    wire       stretch_done;
    wire       wd_done;
    wire       fall_sel;
    wire       sck_rise;
    wire       sck_fall;
    wire       locked;
    wire       wd_off;
    wire [7:0] next_byte;
    wire       wp_n_s;
    wire       wd_trip;
    reg        low_power;

    // every pin from the outside except NV_WRITE_BUSY and SR_INIT passes two flops first
    // select resets to "selected": a select already low at power-up is not a fall
    srw_sync u_sync_sel (
        .CLK     (CLK),
        .SRST    (SRST),
        .RST_VAL (1'b1),
        .D       (~SELECT_AND_KICK_INPUT_N),
        .Q       (sel_n)
    );
    srw_sync u_sync_sck (
        .CLK     (CLK),
        .SRST    (SRST),
        .RST_VAL (1'b0),
        .D       (SCK),
        .Q       (sck_s)
    );
    srw_sync u_sync_si (
        .CLK     (CLK),
        .SRST    (SRST),
        .RST_VAL (1'b0),
        .D       (SI),
        .Q       (si_s)
    );
    srw_sync u_sync_low (
        .CLK     (CLK),
        .SRST    (SRST),
        .RST_VAL (1'b0),
        .D       (~SUPPLY_LOW),
        .Q       (low_s)
    );
    // protect pin resets to the protecting level, so a set lock holds from the start
    srw_sync u_sync_wp (
        .CLK     (CLK),
        .SRST    (SRST),
        .RST_VAL (1'b0),
        .D       (WRITE_PROTECT_N),
        .Q       (wp_n_s)
    );
    // the select and supply synchronisers hold inverted senses so reset reads safe:
    // sel_n here is "selected", low_s is "supply good"

    assign fall_sel = sel_n & ~sel_n_d;       // high-to-low on the pin
    assign sck_rise = sck_s & ~sck_d;
    assign sck_fall = ~sck_s & sck_d;
    assign wd_off   = (status[`SRW_SR_PER_HI_BIT:`SRW_SR_PER_LO_BIT] == `SRW_PER_OFF);
    assign locked   = ~wp_n_s & status[`SRW_SR_LOCK_BIT];
    // expiry counts only once: the reset it causes clears the counter behind it
    assign wd_trip  = wd_done & ~wd_off & ~in_reset;
    assign next_byte = {shift[6:0], si_s};

    // edge history registers
    always @(posedge CLK) begin
        if (SRST) begin
            sel_n_d <= 1'b1;                  // matches the select synchroniser reset
            sck_d   <= 1'b0;
        end else begin
            sel_n_d <= sel_n;
            sck_d   <= sck_s;
        end
    end

    // one free-running millisecond time base serves every timer
    always @(posedge CLK) begin
        if (SRST) begin
            tick_cnt <= 32'h00000000;
            tick     <= 1'b0;
        end else if (tick_cnt >= TICK_CYCLES - 1) begin
            tick_cnt <= 32'h00000000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            tick     <= 1'b0;
        end
    end

    // reset stretch: restarted by every low-supply sample, so dips rearm it;
    // a watchdog trip restarts it too, so that reset lasts as long as a power reset
    srw_mscount u_stretch (
        .CLK   (CLK),
        .SRST  (SRST),
        .TICK  (tick),
        .CLEAR (~low_s | wd_trip),
        .LIMIT (`SRW_STRETCH_MS),
        .DONE  (stretch_done)
    );

    // period decode from the two status bits
    always @* begin
        case (status[`SRW_SR_PER_HI_BIT:`SRW_SR_PER_LO_BIT])
            `SRW_PER_LONG:  wd_limit = `SRW_WD_LONG_MS;
            `SRW_PER_MID:   wd_limit = `SRW_WD_MID_MS;
            `SRW_PER_SHORT: wd_limit = `SRW_WD_SHORT_MS;
            default:        wd_limit = {`SRW_MS_W{1'b1}};
        endcase
    end

    // watchdog counts while select is constant, either level; kicks restart it
    srw_mscount u_watchdog (
        .CLK   (CLK),
        .SRST  (SRST),
        .TICK  (tick),
        .CLEAR (fall_sel | in_reset | wd_off),
        .LIMIT (wd_limit),
        .DONE  (wd_done)
    );

    // reset source: supply low, stretch running, or watchdog expiry.
    // a supply below 1V cannot run this logic, so the open-drain pull is held
    // by the pin's own weak-pull default there; above 1V we drive it
    always @(posedge CLK) begin
        if (SRST) begin
            in_reset   <= 1'b1;
            WD_EXPIRED <= 1'b0;
        end else begin
            // set wins over clear; the flag stands for the whole stretched reset
            if (wd_trip) begin
                WD_EXPIRED <= 1'b1;
            end else if (~in_reset || ~low_s) begin
                WD_EXPIRED <= 1'b0;
            end
            if (~low_s || ~stretch_done) begin
                in_reset <= 1'b1;
            end else if (wd_done && !wd_off) begin
                in_reset <= 1'b1;
            end else begin
                in_reset <= 1'b0;
            end
        end
    end

    // open-drain style pin: active level is variant-selected
    assign RESET_OUT = (ACTIVE_HIGH_RESET != 0) ? in_reset : ~in_reset;
    assign RESET_OE  = in_reset;

    // first falling select edge after power-up arms the serial port
    always @(posedge CLK) begin
        if (SRST) begin
            armed <= 1'b0;
        end else if (fall_sel) begin
            armed <= 1'b1;
        end
    end

    // status register held in flops; nonvolatile value loaded once after reset
    // serial engine: opcode, then status read or write
    always @(posedge CLK) begin
        if (SRST) begin
            state   <= ST_IDLE;
            bit_cnt <= 3'h0;
            shift   <= 8'h00;
            out_sr  <= 8'h00;
            SO_OUT  <= 1'b0;
            status  <= `SRW_SR_RESET;
            loaded  <= 1'b0;
        end else begin
            if (!loaded) begin
                status <= SR_INIT & 8'hBC;    // volatile bits start clear
                loaded <= 1'b1;
            end
            status[`SRW_SR_BUSY_BIT] <= NV_WRITE_BUSY;
            if (!sel_n) begin
                state   <= ST_IDLE;
                bit_cnt <= 3'h0;
            end else if (fall_sel) begin
                // armed rises on this same edge; no frame starts without a fall
                state   <= ST_CMD;
                bit_cnt <= 3'h0;
            end else if (state != ST_IDLE && sck_rise) begin
                shift   <= next_byte;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    if (in_reset || !armed) begin
                        state <= ST_IDLE;
                    end else if (state == ST_CMD) begin
                        if (next_byte == `SRW_OP_RDSR) begin
                            state  <= ST_RD;
                            out_sr <= status;
                        end else if (next_byte == `SRW_OP_WRSR) begin
                            state <= status[`SRW_SR_WEL_BIT] ? ST_WR : ST_IDLE;
                        end else if (next_byte == `SRW_OP_WREN) begin
                            status[`SRW_SR_WEL_BIT] <= 1'b1;
                            state <= ST_IDLE;
                        end else if (next_byte == `SRW_OP_WRDI) begin
                            status[`SRW_SR_WEL_BIT]  <= 1'b0;
                            status[`SRW_SR_FLAG_BIT] <= 1'b0;
                            state <= ST_IDLE;
                        end else if (next_byte == `SRW_OP_SFLB) begin
                            status[`SRW_SR_FLAG_BIT] <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (state == ST_WR) begin
                        if (!locked) begin
                            status[`SRW_SR_LOCK_BIT] <= next_byte[`SRW_SR_LOCK_BIT];
                            status[`SRW_SR_PER_HI_BIT:`SRW_SR_BLK_LO_BIT] <=
                                next_byte[`SRW_SR_PER_HI_BIT:`SRW_SR_BLK_LO_BIT];
                        end
                        status[`SRW_SR_WEL_BIT] <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        out_sr <= status;     // repeated status reads
                    end
                end
            end else if (state == ST_RD && sck_fall) begin
                SO_OUT <= out_sr[3'h7 - bit_cnt];
            end
        end
    end

    // standby from a flop, so the pin does not glitch while select settles
    always @(posedge CLK) begin
        if (SRST) begin
            low_power <= 1'b0;
        end else begin
            low_power <= ~sel_n & ~NV_WRITE_BUSY;
        end
    end

    // output driven only while selected and reading
    assign SO_OE      = sel_n & (state == ST_RD) & ~in_reset;
    assign STANDBY    = low_power;
    assign STATUS_REG = status;
endmodule // srw_supervisor

// ==== bench/srw_supervisor_props.sv ====
// concurrent checks on the supervisor pins
`timescale 1ns/100ps
module srw_supervisor_props #(
    parameter ACTIVE_HIGH_RESET = 0,
    parameter TICK_CYCLES       = 4
) (
    input wire       CLK,
    input wire       SRST,
    input wire       SUPPLY_LOW,
    input wire       SELECT_AND_KICK_INPUT_N,
    input wire       SCK,
    input wire       WRITE_PROTECT_N,
    input wire       NV_WRITE_BUSY,
    input wire       SO_OUT,
    input wire       SO_OE,
    input wire       RESET_OUT,
    input wire       RESET_OE,
    input wire       STANDBY,
    input wire [7:0] STATUS_REG,
    input wire       WD_EXPIRED
);
    integer good_cnt;
    integer quiet_cnt;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // pin-side age of good supply and of the last select fall; slack covers the synchroniser
    always @(posedge CLK) begin
        good_cnt  <= (SRST || SUPPLY_LOW) ? 0 : good_cnt + 1;
        quiet_cnt <= (SRST || $fell(SELECT_AND_KICK_INPUT_N)) ? 0 : quiet_cnt + 1;
    end
    AST_RST_LEVEL: assert property (RESET_OE |-> RESET_OUT == ACTIVE_HIGH_RESET[0])
        else $error("reset pin level wrong while active");
    AST_SUPPLY_LOW: assert property (SUPPLY_LOW [*5] |-> RESET_OE)
        else $error("low supply without reset");
    AST_STRETCH: assert property ($fell(RESET_OE) |-> good_cnt >= 199 * TICK_CYCLES)
        else $error("reset released before the stretch ran out");
    AST_SO_REL: assert property (SELECT_AND_KICK_INPUT_N [*4] |-> !SO_OE)
        else $error("serial output driven while deselected");
    AST_STANDBY: assert property ((SELECT_AND_KICK_INPUT_N && !NV_WRITE_BUSY) [*4] |-> STANDBY)
        else $error("no standby while deselected and idle");
    AST_NO_OP_IN_RESET: assert property (RESET_OE |-> !SO_OE)
        else $error("serial output driven during reset");
    AST_SO_FALL: assert property (SO_OE && $past(SO_OE) && SO_OUT != $past(SO_OUT)
        |-> $past(SCK, 5) || $past(SCK, 6))
        else $error("serial output changed away from a clock fall");
    AST_WD_RESET: assert property ($rose(WD_EXPIRED) |-> ##[0:2] RESET_OE)
        else $error("watchdog expiry without reset");
    AST_WD_QUIET: assert property ($rose(WD_EXPIRED) |-> quiet_cnt >= 198 * TICK_CYCLES)
        else $error("watchdog expired too soon after a kick");
    AST_WD_OFF: assert property ((STATUS_REG[5:4] == 2'h3) [*2] |-> !$rose(WD_EXPIRED))
        else $error("watchdog expired while disabled");
    AST_LOCK: assert property (!RESET_OE && !WRITE_PROTECT_N && STATUS_REG[7]
        && !$past(WRITE_PROTECT_N, 3) |=> $stable(STATUS_REG[7:2]))
        else $error("locked status bits changed");
endmodule // srw_supervisor_props

bind srw_supervisor srw_supervisor_props #(
    .ACTIVE_HIGH_RESET(ACTIVE_HIGH_RESET),
    .TICK_CYCLES(TICK_CYCLES)
) u_props (.CLK(CLK), .SRST(SRST), .SUPPLY_LOW(SUPPLY_LOW),
    .SELECT_AND_KICK_INPUT_N(SELECT_AND_KICK_INPUT_N), .SCK(SCK),
    .WRITE_PROTECT_N(WRITE_PROTECT_N), .NV_WRITE_BUSY(NV_WRITE_BUSY), .SO_OUT(SO_OUT),
    .SO_OE(SO_OE), .RESET_OUT(RESET_OUT), .RESET_OE(RESET_OE), .STANDBY(STANDBY),
    .STATUS_REG(STATUS_REG), .WD_EXPIRED(WD_EXPIRED));

// ==== bench/srw_host_model.sv ====
// host model: drives select, serial clock and data, reads the serial output
`timescale 1ns/100ps
`include "srw_consts.vh"
module srw_host_model (
    input  wire CLK,
    input  wire SO_OUT,
    input  wire SO_OE,
    output reg  SEL_N,
    output reg  SCK,
    output reg  SI
);
    reg       so_last;
    reg       oe_seen;
    reg [7:0] rx;
    wire      so_wire = SO_OE ? SO_OUT : ~so_last; // released line never shows a stale bit
    // select starts low so the first frame has no falling select edge
    initial begin
        SEL_N = 1'b0;
        SCK = 1'b0;
        SI = 1'b0;
        so_last = 1'b0;
        oe_seen = 1'b0;
    end
    // remember the last driven bit and whether the output was driven since the frame opened
    always @(posedge CLK) begin
        if (SO_OE) begin
            so_last <= SO_OUT;
            oe_seen <= 1'b1;
        end
    end
    task half(input b, input c);
        begin
            SI = b;
            SCK = c;
            repeat (4) @(negedge CLK);
        end
    endtask
    // one byte, most significant bit first; reads sampled late in the high phase
    task put(input [7:0] b);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                half(b[i], 1'b0);
                half(b[i], 1'b1);
                rx = {rx[6:0], so_wire};
            end
        end
    endtask
    task open_frame;
        begin
            SEL_N = 1'b0;
            oe_seen = 1'b0;
            repeat (4) @(negedge CLK);
        end
    endtask
    task close_frame;
        begin
            half(1'b0, 1'b0);
            SEL_N = 1'b1;
            repeat (4) @(negedge CLK);
        end
    endtask
    task rdsr(output [7:0] v);
        begin
            open_frame;
            put(`SRW_OP_RDSR);
            put(8'h00);
            close_frame;
            v = rx;
        end
    endtask
    // one-byte instruction frame
    task cmd(input [7:0] c);
        begin
            open_frame;
            put(c);
            close_frame;
        end
    endtask
    task wrsr(input [7:0] d);
        begin
            cmd(`SRW_OP_WREN);
            open_frame;
            put(`SRW_OP_WRSR);
            put(d);
            close_frame;
        end
    endtask
    task kick;
        begin
            SEL_N = 1'b0;
            repeat (4) @(negedge CLK);
            SEL_N = 1'b1;
        end
    endtask
endmodule // srw_host_model

// ==== bench/srw_supervisor_bench.sv ====
// self-checking bench for the supervisor, watchdog and status front end
`timescale 1ns/100ps
module srw_supervisor_bench;
    localparam T = 4; // clocks per tick, shortens every count
    reg        CLK;
    reg        SRST;
    reg        SUPPLY_LOW;
    reg        WRITE_PROTECT_N;
    reg        NV_WRITE_BUSY;
    reg  [7:0] rd;
    wire       SEL_N, SCK, SI, SO_OUT, SO_OE, RESET_OUT, RESET_OE, STANDBY, WD_EXPIRED;
    wire [7:0] STATUS_REG;
    integer    err_count;
    integer    samples_checked;
    srw_supervisor #(.TICK_CYCLES(T)) u_dut (.CLK(CLK), .SRST(SRST), .SUPPLY_LOW(SUPPLY_LOW),
        .SELECT_AND_KICK_INPUT_N(SEL_N), .SCK(SCK), .SI(SI), .WRITE_PROTECT_N(WRITE_PROTECT_N),
        .NV_WRITE_BUSY(NV_WRITE_BUSY), .SR_INIT(8'h77), .SO_OUT(SO_OUT), .SO_OE(SO_OE),
        .RESET_OUT(RESET_OUT), .RESET_OE(RESET_OE), .STANDBY(STANDBY),
        .STATUS_REG(STATUS_REG), .WD_EXPIRED(WD_EXPIRED));
    srw_host_model u_host (.CLK(CLK), .SO_OUT(SO_OUT), .SO_OE(SO_OE), .SEL_N(SEL_N),
        .SCK(SCK), .SI(SI));
    task chk(input [8*12:1] name, input [7:0] exp, input [7:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("Error %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task w(input integer n);
        repeat (n * T) @(negedge CLK);
    endtask
    // supply low then good; the probe read lands inside the stretch
    task pwr(input probe);
        begin
            SUPPLY_LOW = 1'b1;
            w(3);
            chk("reset_drive", 8'h01, RESET_OE);
            chk("reset_level", 8'h00, RESET_OUT);
            SUPPLY_LOW = 1'b0;
            if (probe) begin
                u_host.rdsr(rd);
                chk("blocked_read", 8'h00, u_host.oe_seen);
                w(160);
            end else w(195);
            chk("reset_held", 8'h01, RESET_OE);
            w(10);
            chk("reset_freed", 8'h00, RESET_OE);
        end
    endtask
    task give_verdict;
        begin
            $display("counts: %0d checks, %0d mismatches", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // 40 MHz clock
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // hang guard, far beyond the planned run
    initial begin
        #2000000;
        err_count = err_count + 1;
        $display("Error watchdog expected finish seen hang");
        give_verdict;
    end
    initial begin
        err_count = 0;
        samples_checked = 0;
        SRST = 1'b1;
        SUPPLY_LOW = 1'b1;
        WRITE_PROTECT_N = 1'b1;
        NV_WRITE_BUSY = 1'b0;
        repeat (6) @(negedge CLK);
        SRST = 1'b0;
        repeat (2) @(negedge CLK);
        chk("status_init", 8'h34, STATUS_REG);
        pwr(1'b0);
        $display("test power_up done");
        u_host.rdsr(rd);
        chk("first_fall", 8'h00, u_host.oe_seen);
        chk("standby", 8'h01, STANDBY);
        NV_WRITE_BUSY = 1'b1;
        w(1);
        chk("busy_awake", 8'h00, STANDBY);
        NV_WRITE_BUSY = 1'b0;
        u_host.rdsr(rd);
        chk("status_read", 8'h34, rd);
        $display("test serial_read done");
        u_host.wrsr(8'h20);
        chk("period_bits", 8'h08, STATUS_REG[7:2]);
        repeat (3) begin
            w(150);
            u_host.kick;
        end
        chk("kicked_alive", 8'h00, RESET_OE);
        w(194);
        chk("wd_waiting", 8'h00, RESET_OE);
        w(10);
        chk("wd_reset", 8'h01, RESET_OE);
        chk("wd_flag", 8'h01, WD_EXPIRED);
        repeat (2) begin
            w(100);
            u_host.kick;
        end
        w(3);
        chk("wd_released", 8'h00, RESET_OE);
        chk("wd_flag_off", 8'h00, WD_EXPIRED);
        $display("test watchdog done");
        WRITE_PROTECT_N = 1'b0;
        u_host.wrsr(8'h90);
        chk("lock_set", 8'h24, STATUS_REG[7:2]);
        u_host.wrsr(8'hBC);
        chk("locked", 8'h24, STATUS_REG[7:2]);
        WRITE_PROTECT_N = 1'b1;
        u_host.wrsr(8'h3C);
        chk("unlocked", 8'h0F, STATUS_REG[7:2]);
        $display("test lock done");
        u_host.cmd(8'h00);
        chk("flag_set", 8'h01, STATUS_REG[6]);
        u_host.cmd(8'h06);
        chk("wel_set", 8'h01, STATUS_REG[1]);
        u_host.cmd(8'h04);
        chk("flag_clear", 8'h00, {STATUS_REG[6], STATUS_REG[1]});
        $display("test commands done");
        w(250);
        chk("wd_off", 8'h00, RESET_OE);
        pwr(1'b1);
        $display("test supply_dip done");
        give_verdict;
    end
endmodule // srw_supervisor_bench
